// [keyed_flash_params.svh]
/*
  constants of the keyed flash access unit: register indices, region keys,
  region bounds, erase walk length and reset values.
  assumes inclusion by bare name from every file that needs them.
*/
`ifndef KEYED_FLASH_PARAMS_SVH
`define KEYED_FLASH_PARAMS_SVH

// ------------------------------------------------------------
// register indices (16-bit register numbers, high half first)
// ------------------------------------------------------------
`define KEY_REG_IDX 16'hF168
`define RD_PTR_IDX 16'hF172
`define RD_DATA_IDX 16'hF174
`define ERASE_IDX 16'hF17C
`define PRG_PTR_IDX 16'hF186
`define PRG_DATA_IDX 16'hF188

// ------------------------------------------------------------
// region keys and bounds (byte addresses, end exclusive)
// ------------------------------------------------------------
`define USER_KEY 32'h6615_E336
`define CAL_KEY 32'h43A2_4C42
`define USER_BASE 32'h0000_0000
`define USER_END 32'h0020_0000
`define RSVD_BASE 32'h0020_0000
`define CAL_BASE 32'h003C_4000
`define CAL_END 32'h003C_5000

// ------------------------------------------------------------
// word and sector layout
// ------------------------------------------------------------
`define WORD_STEP 32'h0000_0004
`define SECTOR_MASK 32'hFFFF_F000
`define SECTOR_LAST_WORD 10'h3FF
`define ERASE_BUSY_LAST 11'h3FF
`define ERASED_WORD 32'hFFFF_FFFF

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define REG_RESET 32'h0000_0000
`define HALF_RESET 16'h0000

`endif

// [flash_pkg.sv]
/*
  types shared by the keyed flash access unit and its storage array.
  assumes nothing of its surroundings.
*/
package flash_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_ERASE = 2'b10
  } ctrl_state_t;
  typedef logic [19:0] word_addr_t;
  typedef logic [31:0] word_t;
endpackage

// [flash_mem_if.sv]
/*
  word port between the access controller and the flash storage array.
  assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface flash_mem_if;
  logic rd_en;
  logic wr_en;
  logic wr_and;
  flash_pkg::word_addr_t addr;
  flash_pkg::word_t wdata;
  flash_pkg::word_t rdata;
  modport ctrl (output rd_en, output wr_en, output wr_and, output addr, output wdata, input rdata);
  modport store (input rd_en, input wr_en, input wr_and, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// [flash_array.sv]
/*
  4 MB non-volatile storage as 1M words of 32 bits, registered read data.
  assumes the controller erases before programming; programming only clears bits.
*/
`timescale 1ns/10ps
`default_nettype none
module flash_array (
  input wire logic sys_clk,
  flash_mem_if.store mem
);
  flash_pkg::word_t cells_q [0:(1 << 20) - 1];
  flash_pkg::word_t rdata_q;

  // program ands into the cell, erase overwrites with ones
  always_ff @(posedge sys_clk) begin
    if (mem.wr_en) begin
      cells_q[mem.addr] <= mem.wr_and ? (cells_q[mem.addr] & mem.wdata) : mem.wdata;
    end
    if (mem.rd_en) begin
      rdata_q <= cells_q[mem.addr];
    end
  end

  assign mem.rdata = rdata_q;
endmodule // flash_array
`default_nettype wire

// [keyed_flash_access.sv]
/*
  keyed access unit for 4 MB internal flash: key, read pointer and data port,
  sector erase, program pointer and data buffer, all as 16-bit registers.
  assumes a register agent on sys_clk that pulses packet_done after each packet.
*/
`timescale 1ns/10ps
`default_nettype none
`include "keyed_flash_params.svh"
module keyed_flash_access (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_req,
  input wire logic reg_wr,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic packet_done,
  output logic reg_busy,
  output logic reg_ack,
  output logic [15:0] reg_rdata,
  output logic access_refused
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic pair_hit(input logic [15:0] a, input logic [15:0] base);
    pair_hit = (a[15:1] == base[15:1]);
  endfunction

  function automatic logic allowed(input logic [31:0] key, input logic [31:0] addr);
    allowed = ((key == `USER_KEY) && (addr >= `USER_BASE) && (addr < `USER_END)) ||
              ((key == `CAL_KEY) && (addr >= `CAL_BASE) && (addr < `CAL_END));
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  flash_mem_if mem ();
  flash_pkg::ctrl_state_t state_q, state_d;
  logic [31:0] key_q, rd_ptr_q, prg_ptr_q;
  logic [15:0] stage_q, pstage_q, rhold_q, reg_rdata_q;
  logic rphase_q, pphase_q, reg_ack_q, refused_q;
  logic [9:0] erase_sec_q, erase_cnt_q;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire accept = reg_req && (state_q == flash_pkg::ST_IDLE);
  wire acc_wr = accept && reg_wr;
  wire acc_rd = accept && !reg_wr;
  wire hit_key = pair_hit(reg_addr, `KEY_REG_IDX);
  wire hit_rptr = pair_hit(reg_addr, `RD_PTR_IDX);
  wire hit_rdat = pair_hit(reg_addr, `RD_DATA_IDX);
  wire hit_erase = pair_hit(reg_addr, `ERASE_IDX);
  wire hit_pptr = pair_hit(reg_addr, `PRG_PTR_IDX);
  wire hit_pdat = pair_hit(reg_addr, `PRG_DATA_IDX);
  wire lo_half = reg_addr[0];
  wire [31:0] full_word = {stage_q, reg_wdata};
  wire key_commit = acc_wr && hit_key && lo_half;
  wire rptr_commit = acc_wr && hit_rptr && lo_half;
  wire pptr_commit = acc_wr && hit_pptr && lo_half;
  wire erase_commit = acc_wr && hit_erase && lo_half;
  wire [31:0] erase_addr = full_word & `SECTOR_MASK;
  wire erase_go = erase_commit && allowed(key_q, erase_addr);
  // buffer ports alternate halves on their own, high half first
  wire prog_lo = acc_wr && hit_pdat && pphase_q;
  wire prog_go = prog_lo && allowed(key_q, prg_ptr_q);
  wire rd_fetch = acc_rd && hit_rdat && !rphase_q;
  wire rd_lo = acc_rd && hit_rdat && rphase_q;
  wire refuse = (erase_commit && !erase_go) || (prog_lo && !prog_go);
  wire erase_end = (state_q == flash_pkg::ST_ERASE) && (erase_cnt_q == `SECTOR_LAST_WORD);
  wire in_fetch = (state_q == flash_pkg::ST_FETCH);
  wire [31:0] reg_val = hit_key ? key_q : hit_rptr ? rd_ptr_q : hit_pptr ? prg_ptr_q : `REG_RESET;
  wire [15:0] reg_half = lo_half ? reg_val[15:0] : reg_val[31:16];
  wire [15:0] rd_half = rd_lo ? rhold_q : reg_half;
  wire ack_d = (accept && !rd_fetch && !erase_go) || in_fetch || erase_end;
  wire [15:0] rdata_d = in_fetch ? mem.rdata[31:16] : acc_rd ? rd_half : reg_rdata_q;

  // ------------------------------------------------------------
  // storage port
  // ------------------------------------------------------------
  assign mem.rd_en = rd_fetch;
  assign mem.wr_en = prog_go || (state_q == flash_pkg::ST_ERASE);
  assign mem.wr_and = (state_q != flash_pkg::ST_ERASE);
  assign mem.addr = (state_q == flash_pkg::ST_ERASE) ? {erase_sec_q, erase_cnt_q} :
                    prog_go ? prg_ptr_q[21:2] : rd_ptr_q[21:2];
  assign mem.wdata = (state_q == flash_pkg::ST_ERASE) ? `ERASED_WORD : {pstage_q, reg_wdata};

  flash_array u_array (
    .sys_clk(sys_clk),
    .mem(mem.store)
  );

  // ------------------------------------------------------------
  // control
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      flash_pkg::ST_IDLE: begin
        if (rd_fetch) begin
          state_d = flash_pkg::ST_FETCH;
        end else if (erase_go) begin
          state_d = flash_pkg::ST_ERASE;
        end
      end
      flash_pkg::ST_FETCH: state_d = flash_pkg::ST_IDLE;
      flash_pkg::ST_ERASE: begin
        if (erase_end) begin
          state_d = flash_pkg::ST_IDLE;
        end
      end
      default: state_d = flash_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= flash_pkg::ST_IDLE;
      reg_ack_q <= 1'b0;
      refused_q <= 1'b0;
      reg_rdata_q <= `HALF_RESET;
    end else begin
      state_q <= state_d;
      reg_ack_q <= ack_d;
      refused_q <= refuse;
      reg_rdata_q <= rdata_d;
    end
  end

  // staging of high halves, and the held low half of a read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage_q <= `HALF_RESET;
      pstage_q <= `HALF_RESET;
      rhold_q <= `HALF_RESET;
    end else begin
      if (acc_wr && !lo_half) stage_q <= reg_wdata;
      if (acc_wr && hit_pdat && !pphase_q) pstage_q <= reg_wdata;
      if (in_fetch) rhold_q <= mem.rdata[15:0];
    end
  end

  // key: a commit in the closing cycle of a packet survives the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      key_q <= `REG_RESET;
    end else if (key_commit) begin
      key_q <= full_word;
    end else if (packet_done) begin
      key_q <= `REG_RESET;
    end
  end

  // pointers and half phases
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_ptr_q <= `REG_RESET;
      prg_ptr_q <= `REG_RESET;
      rphase_q <= 1'b0;
      pphase_q <= 1'b0;
    end else begin
      if (rptr_commit) begin
        rd_ptr_q <= full_word;
      end else if (in_fetch) begin
        rd_ptr_q <= rd_ptr_q + `WORD_STEP;
      end
      if (pptr_commit) begin
        prg_ptr_q <= full_word;
      end else if (prog_go) begin
        prg_ptr_q <= prg_ptr_q + `WORD_STEP;
      end
      if (rptr_commit || packet_done) begin
        rphase_q <= 1'b0;
      end else if (in_fetch || rd_lo) begin
        rphase_q <= !rphase_q;
      end
      if (pptr_commit || packet_done) begin
        pphase_q <= 1'b0;
      end else if (acc_wr && hit_pdat) begin
        pphase_q <= !pphase_q;
      end
    end
  end

  // sector walk
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      erase_sec_q <= 10'h000;
      erase_cnt_q <= 10'h000;
    end else if (erase_go) begin
      erase_sec_q <= erase_addr[21:12];
      erase_cnt_q <= 10'h000;
    end else if (state_q == flash_pkg::ST_ERASE) begin
      erase_cnt_q <= erase_cnt_q + 10'h001;
    end
  end

  assign reg_busy = (state_q != flash_pkg::ST_IDLE);
  assign reg_ack = reg_ack_q;
  assign reg_rdata = reg_rdata_q;
  assign access_refused = refused_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // length of the current busy stretch, kept apart from the sector walk
  logic [10:0] busy_run_q;
  always_ff @(posedge sys_clk) begin
    if (rst || !reg_busy) begin
      busy_run_q <= 11'h000;
    end else begin
      busy_run_q <= busy_run_q + 11'h001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  key_clear_a: assert property (packet_done && !key_commit |=> key_q == `REG_RESET)
    else $error("key survived end of packet");
  refuse_nokey_a: assert property (prog_lo && !allowed(key_q, prg_ptr_q) |-> !mem.wr_en ##1 access_refused)
    else $error("program not refused without key");
  user_bound_a: assert property (mem.wr_en && mem.wr_and && key_q == `USER_KEY |-> mem.addr < 20'h8_0000)
    else $error("user key wrote outside user region");
  cal_bound_a: assert property (mem.wr_en && mem.wr_and && key_q == `CAL_KEY
                                |-> mem.addr >= 20'hF_1000 && mem.addr < 20'hF_1400)
    else $error("calibration key wrote outside its sector");
  erase_round_a: assert property (erase_go |=> erase_sec_q == $past(full_word[21:12]) && erase_cnt_q == 10'h000)
    else $error("erase sector not rounded down");
  erase_ones_a: assert property (state_q == flash_pkg::ST_ERASE
                                 |-> mem.wr_en && !mem.wr_and && mem.wdata == `ERASED_WORD)
    else $error("erase did not write ones");
  erase_len_a: assert property (erase_end |-> (busy_run_q == `ERASE_BUSY_LAST && !reg_ack) ##1 (reg_ack && !reg_busy))
    else $error("erase walk not one sector long");
  prog_step_a: assert property (prog_go |=> prg_ptr_q == $past(prg_ptr_q) + `WORD_STEP)
    else $error("program pointer did not step four");
  fetch_step_a: assert property (rd_fetch |=> in_fetch ##1 (reg_ack && rd_ptr_q == $past(rd_ptr_q, 2) + `WORD_STEP))
    else $error("read fetch did not answer and step");

  erase_done_c: cover property (erase_end && busy_run_q == `ERASE_BUSY_LAST);
  prog_word_c: cover property (prog_go ##1 prog_go);
  read_pair_c: cover property (rd_fetch ##2 rd_lo);
  refused_c: cover property (access_refused);
endmodule // keyed_flash_access
`default_nettype wire

// [tb.sv]
/*
  self-checking bench for the keyed flash access unit: register read-back,
  keyed erase and program, refusals, read-back through the data port.
  assumes the design files are compiled first; includes the keyed flash constants header by bare name.
*/
`timescale 1ns/10ps
`default_nettype none
`include "keyed_flash_params.svh"
module tb;
  typedef struct packed {logic [15:0] idx; logic [31:0] wval; logic [31:0] rval;} row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_req = 1'b0;
  logic reg_wr = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic packet_done = 1'b0;
  logic reg_busy;
  logic reg_ack;
  logic [15:0] reg_rdata;
  logic access_refused;
  logic [15:0] got_data;
  logic got_ref;
  logic [31:0] rd_word;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // rows: register, value written, value read back (unmapped reads zero)
  row_t rows [4] = '{'{`RD_PTR_IDX, 32'h0000_1004, 32'h0000_1004}, '{`PRG_PTR_IDX, 32'h0000_2008, 32'h0000_2008},
    '{`KEY_REG_IDX, 32'h0123_4567, 32'h0123_4567}, '{16'hF170, 32'hDEAD_BEEF, 32'h0000_0000}};

  keyed_flash_access dut (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .packet_done(packet_done), .reg_busy(reg_busy), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .access_refused(access_refused));

  // ------------------------------------------------------------
  // clock, timeout and verdict
  // ------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;

  task automatic results();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      results();
    end
  end

  // ------------------------------------------------------------
  // compares and register access
  // ------------------------------------------------------------
  task automatic chk_data(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_flag(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  // request held until an edge with busy low takes it, then wait for the answer
  task automatic acc(input logic wr, input logic [15:0] addr, input logic [15:0] data);
    int n;
    n = 0;
    @(posedge sys_clk);
    reg_req <= 1'b1;
    reg_wr <= wr;
    reg_addr <= addr;
    reg_wdata <= data;
    @(negedge sys_clk);
    while (reg_busy !== 1'b0 && n < 3000) begin
      n++;
      @(negedge sys_clk);
    end
    @(posedge sys_clk);
    reg_req <= 1'b0;
    @(negedge sys_clk);
    while (reg_ack !== 1'b1 && n < 3000) begin
      n++;
      @(negedge sys_clk);
    end
    got_data = reg_rdata;
    got_ref = access_refused;
    if (n >= 3000) begin
      bad_count++;
      $display("mismatch handshake expected ack seen timeout");
    end
  endtask

  task automatic w32(input logic [15:0] idx, input logic [31:0] val);
    acc(1'b1, idx, val[31:16]);
    acc(1'b1, idx + 16'h0001, val[15:0]);
  endtask

  task automatic r32(input logic [15:0] idx);
    acc(1'b0, idx, 16'h0000);
    rd_word[31:16] = got_data;
    acc(1'b0, idx + 16'h0001, 16'h0000);
    rd_word[15:0] = got_data;
  endtask

  task automatic pkt();
    @(posedge sys_clk);
    packet_done <= 1'b1;
    @(posedge sys_clk);
    packet_done <= 1'b0;
  endtask

  task automatic readw(input logic [31:0] addr);
    w32(`RD_PTR_IDX, addr);
    r32(`RD_DATA_IDX);
  endtask

  // one packet: key, erase address, packet end
  task automatic erase(input logic [31:0] key, input logic [31:0] addr);
    w32(`KEY_REG_IDX, key);
    w32(`ERASE_IDX, addr);
    pkt();
  endtask

  // one packet: key, pointer, two data words, packet end
  task automatic prog(input logic [31:0] key, input logic [31:0] addr, input logic [31:0] d0, input logic [31:0] d1);
    w32(`KEY_REG_IDX, key);
    w32(`PRG_PTR_IDX, addr);
    w32(`PRG_DATA_IDX, d0);
    w32(`PRG_DATA_IDX, d1);
    pkt();
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (7) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_flag("ack_in_reset", 1'b0, reg_ack);
    chk_flag("busy_in_reset", 1'b0, reg_busy);
    chk_data("rdata_in_reset", 32'h0000_0000, {16'h0000, reg_rdata});
    @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      w32(rows[i].idx, rows[i].wval);
      r32(rows[i].idx);
      chk_data("reg_readback", rows[i].rval, rd_word);
    end
    pkt();
    r32(`KEY_REG_IDX);
    chk_data("key_after_packet", `REG_RESET, rd_word);
    erase(`USER_KEY, 32'h0000_1234);
    chk_flag("user_erase_refused", 1'b0, got_ref);
    readw(32'h0000_1000);
    chk_data("sector_first_word", `ERASED_WORD, rd_word);
    readw(32'h0000_1FFC);
    chk_data("sector_last_word", `ERASED_WORD, rd_word);
    prog(`USER_KEY, 32'h0000_1000, 32'h1234_5678, 32'h9ABC_DEF0);
    chk_flag("user_prog_refused", 1'b0, got_ref);
    w32(`RD_PTR_IDX, 32'h0000_1000);
    r32(`RD_DATA_IDX);
    chk_data("word_at_0", 32'h1234_5678, rd_word);
    r32(`RD_DATA_IDX);
    chk_data("word_at_4", 32'h9ABC_DEF0, rd_word);
    w32(`PRG_PTR_IDX, 32'h0000_1008);
    w32(`PRG_DATA_IDX, 32'h0000_0000);
    chk_flag("unkeyed_prog_refused", 1'b1, got_ref);
    prog(`CAL_KEY, 32'h0000_100C, 32'h0000_0000, 32'h0000_0000);
    chk_flag("wrong_key_prog_refused", 1'b1, got_ref);
    readw(32'h0000_1008);
    chk_data("unkeyed_word_kept", `ERASED_WORD, rd_word);
    readw(32'h0000_100C);
    chk_data("wrong_key_word_kept", `ERASED_WORD, rd_word);
    erase(`CAL_KEY, 32'h0000_1000);
    chk_flag("wrong_key_erase_refused", 1'b1, got_ref);
    readw(32'h0000_1000);
    chk_data("programmed_word_kept", 32'h1234_5678, rd_word);
    erase(`USER_KEY, 32'h0020_0000);
    chk_flag("reserved_erase_refused", 1'b1, got_ref);
    erase(`CAL_KEY, 32'h003C_4FF0);
    chk_flag("cal_erase_refused", 1'b0, got_ref);
    readw(32'h003C_4000);
    chk_data("cal_first_word", `ERASED_WORD, rd_word);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    r32(`RD_PTR_IDX);
    chk_data("pointer_after_reset", `REG_RESET, rd_word);
    results();
  end
endmodule // tb
`default_nettype wire
